// ===== verilog/bwd_defs.svh
// constants for the burst, wrap and decimation control block
// assumes inclusion by the package and the design modules only
`ifndef BWD_DEFS_SVH
`define BWD_DEFS_SVH
// register offset and field positions
`define BWD_CTRL_ADDR 7'h30
`define BWD_CTRL_RESET 8'h00
`define BWD_SEL_LSB 0
`define BWD_SEL_MSB 3
`define BWD_LINEAR_BIT 4
`define BWD_WRAP_SEL_BIT 5
`define BWD_RESV_BIT 6
`define BWD_BURST_BIT 7
// read pointer wrap points
`define BWD_X_LOW_ADDR 7'h0D
`define BWD_Z_HIGH_ADDR 7'h12
`define BWD_INT_FLAG_ADDR 7'h14
// fifo transaction sample counts
`define BWD_SINGLE_SAMPLES 6'h01
`define BWD_BURST_MIN 6'h02
`define BWD_BURST_MAX 6'h20
// decimation divisors per selector code
`define BWD_DIV_0 10'h001
`define BWD_DIV_1 10'h002
`define BWD_DIV_2 10'h004
`define BWD_DIV_3 10'h005
`define BWD_DIV_4 10'h008
`define BWD_DIV_5 10'h00A
`define BWD_DIV_6 10'h010
`define BWD_DIV_7 10'h014
`define BWD_DIV_8 10'h028
`define BWD_DIV_9 10'h043
`define BWD_DIV_A 10'h050
`define BWD_DIV_B 10'h064
`define BWD_DIV_C 10'h0C8
`define BWD_DIV_D 10'h0FA
`define BWD_DIV_E 10'h1F4
`define BWD_DIV_F 10'h3E8
`endif

// ===== verilog/bwd_pkg.sv
// types and the divisor lookup for the burst, wrap and decimation block
// assumes bwd_defs.svh is on the include path
`include "bwd_defs.svh"
package bwd_pkg;
  // decimation selector code
  typedef logic [3:0] decim_sel_t;
  // divisor count, wide enough for 1000
  typedef logic [9:0] decim_div_t;
  // fifo read transaction state
  typedef enum logic {FIFO_IDLE, FIFO_DRAIN} fifo_rd_state_t;

  // maps a selector code to its divide factor
  function automatic decim_div_t decim_divisor(input decim_sel_t sel);
    decim_div_t d;
    d = `BWD_DIV_0;
    unique case (sel)
      4'h0: d = `BWD_DIV_0;
      4'h1: d = `BWD_DIV_1;
      4'h2: d = `BWD_DIV_2;
      4'h3: d = `BWD_DIV_3;
      4'h4: d = `BWD_DIV_4;
      4'h5: d = `BWD_DIV_5;
      4'h6: d = `BWD_DIV_6;
      4'h7: d = `BWD_DIV_7;
      4'h8: d = `BWD_DIV_8;
      4'h9: d = `BWD_DIV_9;
      4'hA: d = `BWD_DIV_A;
      4'hB: d = `BWD_DIV_B;
      4'hC: d = `BWD_DIV_C;
      4'hD: d = `BWD_DIV_D;
      4'hE: d = `BWD_DIV_E;
      4'hF: d = `BWD_DIV_F;
    endcase
    return d;
  endfunction : decim_divisor
endpackage : bwd_pkg

// ===== verilog/decim_counter.sv
// decimating tick counter: one output strobe every n internal ticks
// assumes sample_tick is a one-cycle pulse on ref_clk from the timebase
`timescale 1ns/10ps
module decim_counter import bwd_pkg::*; (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic sample_tick,
  input wire decim_sel_t decim_divisor_sel,
  output logic odr_strobe
);
  decim_sel_t sel_prev_reg; // selector seen last cycle
  decim_div_t cnt_reg; // ticks counted in this output period
  decim_div_t div_last; // terminal count for the selected divisor
  logic sel_chg; // selector moved this cycle

  assign div_last = decim_divisor(decim_divisor_sel) - 10'h001;
  assign sel_chg = (decim_divisor_sel != sel_prev_reg);

  // track selector for change detection
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sel_prev_reg <= 4'h0;
    end else begin
      sel_prev_reg <= decim_divisor_sel;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 10'h000;
      odr_strobe <= 1'b0;
    end else if (sel_chg) begin
      // restart the period; a tick in this cycle is dropped
      cnt_reg <= 10'h000;
      odr_strobe <= 1'b0;
    end else if (sample_tick) begin
      if (cnt_reg >= div_last) begin
        cnt_reg <= 10'h000;
        odr_strobe <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 10'h001;
        odr_strobe <= 1'b0;
      end
    end else begin
      odr_strobe <= 1'b0;
    end
  end
endmodule : decim_counter

// ===== verilog/burst_wrap_decim.sv
// control register for fifo burst reads, pointer wrap and decimation
// assumes register port, pointer and fifo strobes come from ref_clk logic
`timescale 1ns/10ps
`include "bwd_defs.svh"
// Function
// - selector zero passes every internal sample
// - codes one to four divide 2,4,5,8
// - codes five to eight divide 10,16,20,40
// - codes nine to eleven divide 67,80,100
// - codes twelve up divide 200,250,500,1000
// - front end full rate, back end decimated
// - decimation works on any base rate
// - wrap mode wraps at selected address
// - linear mode increments without wrap
// - wrap select zero: 0x12 to 0x0D
// - wrap select one: 0x14 to 0x0D
// - one sample, or 2 to 32 samples
module burst_wrap_decim import bwd_pkg::*; (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic sample_tick,
  output logic adc_lpf_strobe,
  output logic odr_strobe,
  input wire logic addr_start,
  input wire logic [6:0] addr_start_value,
  input wire logic addr_advance,
  output logic [6:0] addr_ptr,
  input wire logic fifo_rd_start,
  input wire logic fifo_sample_done,
  input wire logic [5:0] read_count,
  output logic fifo_burst_en,
  output logic fifo_rd_active,
  output logic [5:0] fifo_samples_left
);
  logic [7:0] burst_wrap_decimation_ctrl_reg; // the control register
  decim_sel_t decim_divisor_sel; // decimation selector field
  logic linear_inc; // linear increment selector
  logic wrap_sel; // wrap point selector
  logic [6:0] wrap_addr; // address at which the pointer wraps
  logic [6:0] addr_ptr_next; // pointer after one byte
  logic [5:0] burst_len; // clamped burst sample count
  fifo_rd_state_t rd_state_reg; // fifo read transaction state

  assign decim_divisor_sel = burst_wrap_decimation_ctrl_reg[`BWD_SEL_MSB:`BWD_SEL_LSB];
  assign linear_inc = burst_wrap_decimation_ctrl_reg[`BWD_LINEAR_BIT];
  assign wrap_sel = burst_wrap_decimation_ctrl_reg[`BWD_WRAP_SEL_BIT];

  // register write; the reserved bit is held at zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      burst_wrap_decimation_ctrl_reg <= `BWD_CTRL_RESET;
    end else if (reg_wr_en && reg_addr == `BWD_CTRL_ADDR) begin
      burst_wrap_decimation_ctrl_reg <= reg_wdata;
      burst_wrap_decimation_ctrl_reg[`BWD_RESV_BIT] <= 1'b0;
    end
  end

  // read data; other addresses answer zero from this block
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rdata <= (reg_addr == `BWD_CTRL_ADDR) ? burst_wrap_decimation_ctrl_reg : 8'h00;
    end
  end

  // burst enable out to the fifo read path
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fifo_burst_en <= 1'b0;
    end else begin
      fifo_burst_en <= burst_wrap_decimation_ctrl_reg[`BWD_BURST_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      adc_lpf_strobe <= 1'b0;
    end else begin
      adc_lpf_strobe <= sample_tick;
    end
  end

  decim_counter u_decim (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .sample_tick(sample_tick),
    .decim_divisor_sel(decim_divisor_sel),
    .odr_strobe(odr_strobe)
  );

  assign wrap_addr = wrap_sel ? `BWD_INT_FLAG_ADDR : `BWD_Z_HIGH_ADDR;

  always_comb begin
    if (!linear_inc && addr_ptr == wrap_addr) begin
      addr_ptr_next = `BWD_X_LOW_ADDR;
    end else begin
      addr_ptr_next = addr_ptr + 7'h01;
    end
  end

  // register address pointer; a new start wins over an advance
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      addr_ptr <= 7'h00;
    end else if (addr_start) begin
      addr_ptr <= addr_start_value;
    end else if (addr_advance) begin
      addr_ptr <= addr_ptr_next;
    end
  end

  always_comb begin
    if (read_count < `BWD_BURST_MIN) begin
      burst_len = `BWD_BURST_MIN;
    end else if (read_count > `BWD_BURST_MAX) begin
      burst_len = `BWD_BURST_MAX;
    end else begin
      burst_len = read_count;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_state_reg <= FIFO_IDLE;
      fifo_samples_left <= 6'h00;
      fifo_rd_active <= 1'b0;
    end else begin
      unique case (rd_state_reg)
        FIFO_IDLE: begin
          if (fifo_rd_start) begin
            rd_state_reg <= FIFO_DRAIN;
            fifo_rd_active <= 1'b1;
            fifo_samples_left <= fifo_burst_en ? burst_len : `BWD_SINGLE_SAMPLES;
          end
        end
        FIFO_DRAIN: begin
          if (fifo_sample_done) begin
            // last sample closes the transaction
            if (fifo_samples_left == `BWD_SINGLE_SAMPLES) begin
              rd_state_reg <= FIFO_IDLE;
              fifo_rd_active <= 1'b0;
            end
            fifo_samples_left <= fifo_samples_left - 6'h01;
          end
        end
      endcase
    end
  end

  // helper: ticks seen since the last output strobe
  logic [10:0] ticks_seen_reg;
  logic primed_reg;
  decim_sel_t sel_seen_reg;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ticks_seen_reg <= 11'h000;
      primed_reg <= 1'b0;
      sel_seen_reg <= 4'h0;
    end else begin
      sel_seen_reg <= decim_divisor_sel;
      if (decim_divisor_sel != sel_seen_reg) begin
        primed_reg <= 1'b0;
        ticks_seen_reg <= 11'h000;
      end else if (odr_strobe) begin
        primed_reg <= 1'b1;
        ticks_seen_reg <= sample_tick ? 11'h001 : 11'h000;
      end else if (sample_tick) begin
        ticks_seen_reg <= ticks_seen_reg + 11'h001;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  AST_NO_DECIM: assert property (
    decim_divisor_sel == 4'h0 && $stable(decim_divisor_sel) && sample_tick |=> odr_strobe)
    else $error("undecimated tick gave no output strobe");
  AST_DIV_LOW: assert property (
    odr_strobe && primed_reg && decim_divisor_sel inside {[4'h1:4'h4]}
      |-> ticks_seen_reg == {1'b0, decim_divisor(decim_divisor_sel)})
    else $error("divide by 2 to 8 period wrong");
  AST_DIV_MID: assert property (
    odr_strobe && primed_reg && decim_divisor_sel inside {[4'h5:4'h8]}
      |-> ticks_seen_reg == {1'b0, decim_divisor(decim_divisor_sel)})
    else $error("divide by 10 to 40 period wrong");
  AST_DIV_HIGH: assert property (
    odr_strobe && primed_reg && decim_divisor_sel inside {[4'h9:4'hB]}
      |-> ticks_seen_reg == {1'b0, decim_divisor(decim_divisor_sel)})
    else $error("divide by 67 to 100 period wrong");
  AST_DIV_TOP: assert property (
    odr_strobe && primed_reg && decim_divisor_sel inside {[4'hC:4'hF]}
      |-> ticks_seen_reg == {1'b0, decim_divisor(decim_divisor_sel)})
    else $error("divide by 200 to 1000 period wrong");
  AST_FRONT_RATE: assert property (
    sample_tick |=> adc_lpf_strobe)
    else $error("front end strobe missed an internal tick");
  AST_STROBE_CAUSE: assert property (
    odr_strobe |-> $past(sample_tick))
    else $error("output strobe without an internal tick");
  AST_WRAP_Z: assert property (
    addr_advance && !addr_start && !linear_inc && !wrap_sel && addr_ptr == 7'h12 |=> addr_ptr == 7'h0D)
    else $error("pointer did not wrap after z high byte");
  AST_WRAP_INT: assert property (
    addr_advance && !addr_start && !linear_inc && wrap_sel && addr_ptr == 7'h14 |=> addr_ptr == 7'h0D)
    else $error("pointer did not wrap after interrupt flags");
  AST_WRAP_PASS: assert property (
    addr_advance && !addr_start && !linear_inc && wrap_sel && addr_ptr == 7'h12 |=> addr_ptr == 7'h13)
    else $error("pointer wrapped at the wrong address");
  AST_LINEAR: assert property (
    addr_advance && !addr_start && linear_inc |=> addr_ptr == $past(addr_ptr) + 7'h01)
    else $error("linear pointer did not step by one");
  AST_SINGLE: assert property (
    rd_state_reg == FIFO_IDLE && fifo_rd_start && !fifo_burst_en |=> fifo_samples_left == 6'h01 && fifo_rd_active)
    else $error("single read did not load one sample");
  AST_BURST_LEN: assert property (
    rd_state_reg == FIFO_IDLE && fifo_rd_start && fifo_burst_en
      |=> fifo_samples_left >= 6'h02 && fifo_samples_left <= 6'h20)
    else $error("burst length outside 2 to 32");
endmodule : burst_wrap_decim

// ===== testbench/host_ctrl_model.sv
// host controller model: register accesses and fifo drain transactions
// assumes one ref_clk domain shared with the block, requests after reset
`timescale 1ns/10ps
module host_ctrl_model (
  input wire logic ref_clk,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  output logic fifo_rd_start,
  output logic fifo_sample_done,
  output logic [5:0] read_count,
  input wire logic fifo_rd_active,
  input wire logic [5:0] fifo_samples_left
);
  // idle levels at time zero
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    fifo_rd_start = 1'b0;
    fifo_sample_done = 1'b0;
    read_count = 6'h00;
  end

  // one register write; released data shows its inverse
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d & 8'hBF;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
    reg_wdata <= ~(d & 8'hBF);
  endtask : wr

  // one register read, data taken 1 ns after the read edge
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // drain one fifo transaction; start held over a second edge on purpose
  // count set before start
  task automatic drain(input logic [5:0] n, output logic [5:0] first, output int got);
    read_count <= n;
    @(posedge ref_clk);
    fifo_rd_start <= 1'b1;
    @(posedge ref_clk);
    fifo_sample_done <= 1'b1;
    #1;
    first = fifo_samples_left;
    got = 0;
    // done pulses back to back while the transaction is draining
    repeat (40) begin
      if (fifo_rd_active !== 1'b1) break;
      got++;
      @(posedge ref_clk);
      fifo_rd_start <= 1'b0;
      #1;
    end
    @(posedge ref_clk);
    fifo_sample_done <= 1'b0;
  endtask : drain
endmodule : host_ctrl_model

// ===== testbench/burst_wrap_decim_tb.sv
// self-checking bench for the burst, wrap and decimation control block
// assumes the host model in its own file and the package compiled first
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_total++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module burst_wrap_decim_tb;
  import bwd_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic sample_tick = 1'b0;
  logic addr_start = 1'b0;
  logic [6:0] addr_start_value = 7'h00;
  logic addr_advance = 1'b0;
  logic reg_wr_en, reg_rd_en, fifo_rd_start, fifo_sample_done;
  logic adc_lpf_strobe, odr_strobe, fifo_burst_en, fifo_rd_active;
  logic [6:0] reg_addr, addr_ptr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [5:0] read_count, fifo_samples_left, f;
  int err_total = 0;
  int n_checks = 0;
  int ticks, odr_n, adc_n, first_at, g;
  int divs[16] = '{1, 2, 4, 5, 8, 10, 16, 20, 40, 67, 80, 100, 200, 250, 500, 1000};
  int cnts[4] = '{2, 32, 1, 40};
  int exps[4] = '{2, 32, 2, 32};

  // 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  burst_wrap_decim burst_wrap_decim_i (.ref_clk(ref_clk), .resetn(resetn), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample_tick(sample_tick), .adc_lpf_strobe(adc_lpf_strobe), .odr_strobe(odr_strobe),
    .addr_start(addr_start), .addr_start_value(addr_start_value), .addr_advance(addr_advance),
    .addr_ptr(addr_ptr), .fifo_rd_start(fifo_rd_start), .fifo_sample_done(fifo_sample_done),
    .read_count(read_count), .fifo_burst_en(fifo_burst_en), .fifo_rd_active(fifo_rd_active),
    .fifo_samples_left(fifo_samples_left));

  host_ctrl_model host_ctrl_model_i (.ref_clk(ref_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fifo_rd_start(fifo_rd_start),
    .fifo_sample_done(fifo_sample_done), .read_count(read_count), .fifo_rd_active(fifo_rd_active),
    .fifo_samples_left(fifo_samples_left));

  // strobe and tick counters; first strobe notes the ticks seen before it
  always @(posedge ref_clk) begin
    if (odr_strobe === 1'b1 && odr_n == 0) first_at = ticks;
    odr_n += (odr_strobe === 1'b1);
    adc_n += (adc_lpf_strobe === 1'b1);
    ticks += (sample_tick === 1'b1);
  end

  // prints counts and verdict, ends the run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  // select a divisor, tick 2n times spaced by gap, count strobes
  task automatic decim(input logic [3:0] s, input int div, input int gap, input int pre);
    host_ctrl_model_i.wr(7'h30, {4'h0, s});
    repeat (3) @(posedge ref_clk);
    #1;
    {ticks, odr_n, adc_n, first_at} = {32'd0, 32'd0, 32'd0, 32'd0};
    repeat (2 * div) begin
      @(posedge ref_clk);
      sample_tick <= 1'b1;
      repeat (gap - 1) begin
        @(posedge ref_clk);
        sample_tick <= 1'b0;
      end
    end
    @(posedge ref_clk);
    sample_tick <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("first strobe tick", div, first_at)
    `CHK("output strobes", 2, odr_n)
    `CHK("front end strobes", 2 * div, adc_n)
  endtask : decim

  // load the pointer and step it six times back to back
  task automatic walk(input logic [7:0] ctl, input logic [6:0] a);
    logic [6:0] e;
    host_ctrl_model_i.wr(7'h30, ctl);
    repeat (2) @(posedge ref_clk);
    addr_start <= 1'b1;
    addr_start_value <= a;
    e = a;
    repeat (7) begin
      @(posedge ref_clk);
      addr_start <= 1'b0;
      addr_start_value <= ~a;
      addr_advance <= 1'b1;
      #1;
      `CHK("addr_ptr", e, addr_ptr)
      if (ctl[4] == 1'b0 && e == (ctl[5] ? 7'h14 : 7'h12)) e = 7'h0D;
      else e = e + 7'h01;
    end
    addr_advance <= 1'b0;
  endtask : walk

  // watchdog
  initial begin
    repeat (30000) @(posedge ref_clk);
    err_total++;
    stop_test();
  end

  // main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    host_ctrl_model_i.rd(7'h30, d);
    `CHK("ctrl reset", 8'h00, d)
    host_ctrl_model_i.wr(7'h30, 8'h95);
    host_ctrl_model_i.wr(7'h31, 8'hFF);
    host_ctrl_model_i.rd(7'h30, d);
    `CHK("ctrl rw", 8'h95, d)
    host_ctrl_model_i.rd(7'h31, d);
    `CHK("unmapped", 8'h00, d)
    $display("test regs done");
    for (int s = 0; s < 16; s++) decim(s[3:0], divs[s], (s < 4) ? 3 : 1, 0);
    host_ctrl_model_i.wr(7'h30, 8'h04);
    repeat (5) begin
      @(posedge ref_clk);
      sample_tick <= 1'b1;
    end
    @(posedge ref_clk);
    sample_tick <= 1'b0;
    decim(4'h1, 2, 1, 0);
    $display("test decimation done");
    walk(8'h00, 7'h10);
    walk(8'h20, 7'h12);
    walk(8'h10, 7'h11);
    $display("test pointer done");
    host_ctrl_model_i.wr(7'h30, 8'h00);
    host_ctrl_model_i.drain(6'h05, f, g);
    `CHK("single left", 6'h01, f)
    `CHK("single samples", 1, g)
    host_ctrl_model_i.wr(7'h30, 8'h80);
    for (int i = 0; i < 4; i++) begin
      host_ctrl_model_i.drain(cnts[i][5:0], f, g);
      `CHK("burst samples", exps[i], g)
      `CHK("burst left", 6'h00, fifo_samples_left)
    end
    $display("test fifo done");
    stop_test();
  end
endmodule : burst_wrap_decim_tb
